//--- shared/ptcw_pkg.sv
package ptcw_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_BTC3       = 4'h0;
  localparam logic [3:0] ADDR_CTRL       = 4'h4;
  // bit timing config three fields
  localparam int         SOF_SEL_BIT     = 7;
  localparam int         WAKE_FILT_BIT   = 6;
  localparam int         PHSEG_MSB       = 2;
  localparam int         PHSEG_LSB       = 0;
  localparam logic [7:0] BTC3_WMASK      = 8'hC7;
  localparam logic [7:0] BTC3_RESET      = 8'h00;
  // controller control fields
  localparam int         OUT_CLK_EN_BIT  = 2;
  localparam logic [7:0] CTRL_WMASK      = 8'h04;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  // timing
  localparam int         CLK_PERIOD_NS   = 8;
  localparam int         WAKE_FILTER_NS  = 50;
  localparam int         WAKE_FILTER_CYC =
    (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         OUT_HALF_CYC    = 1;
endpackage

//--- verilog/ptcw_ps2_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ptcw_phase_two_timer
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       time_quantum_tick,
  input  wire logic       start,
  input  wire logic [2:0] length_field,
  output var  logic       busy,
  output var  logic       done
);
  logic [3:0] cnt_reg;

  // phase segment two lasts field plus one quanta
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 4'h0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_reg <= {1'b0, length_field} + 4'h1;
        busy    <= 1'b1;
      end
      else if (busy && time_quantum_tick)
      begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  property p_phase_two_load;
    @(posedge aclk) disable iff (!aresetn)
    start |=> (cnt_reg == {1'b0, $past(length_field)} + 4'h1) && busy;
  endproperty
  a_phase_two_load: assert property (p_phase_two_load)
    else $error("phase two length not field plus one");

  cover property (@(posedge aclk) disable iff (!aresetn) done);
endmodule
`default_nettype wire

//--- verilog/ptcw_top.sv
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ptcw_top
#(
  parameter int WAKE_CYCLES = ptcw_pkg::WAKE_FILTER_CYC,
  parameter int CLK_HALF    = ptcw_pkg::OUT_HALF_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        frame_start_pulse,
  input  wire logic        time_quantum_tick,
  input  wire logic        phase_two_start,
  input  wire logic        wake_pin,
  output var  logic        clock_output_pin,
  output var  logic        wake_event,
  output var  logic        phase_two_busy,
  output var  logic        phase_two_done
);
  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 255 || CLK_HALF < 1 || CLK_HALF > 255)
  begin : g_param_check
    $error("WAKE_CYCLES or CLK_HALF out of range");
  end
  logic [7:0] btc3_reg;
  logic [7:0] ctrl_reg;
  logic [3:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic       wstrb0_reg;
  logic       aw_full_reg;
  logic       w_full_reg;
  logic       do_write;
  logic       clock_output_enable;
  logic       frame_start_sel;
  logic       wake_filter_enable;
  logic [2:0] phase_segment_two_length;
  assign do_write                 = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign clock_output_enable      = ctrl_reg[ptcw_pkg::OUT_CLK_EN_BIT];
  assign frame_start_sel          = btc3_reg[ptcw_pkg::SOF_SEL_BIT];
  assign wake_filter_enable       = btc3_reg[ptcw_pkg::WAKE_FILT_BIT];
  assign phase_segment_two_length =
    btc3_reg[ptcw_pkg::PHSEG_MSB:ptcw_pkg::PHSEG_LSB];
  ////////////////////////////////////////////////////////////////////////////
  // write channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ptcw_pkg::RESP_OKAY;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      awaddr_reg    <= 4'h0;
      wdata_reg     <= 8'h00;
      wstrb0_reg    <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg   <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg   <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata[7:0];
        wstrb0_reg   <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        if (awaddr_reg == ptcw_pkg::ADDR_BTC3 ||
            awaddr_reg == ptcw_pkg::ADDR_CTRL)
          s_axi_bresp <= ptcw_pkg::RESP_OKAY;
        else
          s_axi_bresp <= ptcw_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        aw_full_reg   <= 1'b0;
        w_full_reg    <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end
  // register storage, unimplemented bits masked off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      btc3_reg <= ptcw_pkg::BTC3_RESET;
      ctrl_reg <= ptcw_pkg::CTRL_RESET;
    end
    else if (do_write && wstrb0_reg)
    begin
      if (awaddr_reg == ptcw_pkg::ADDR_BTC3)
        btc3_reg <= wdata_reg & ptcw_pkg::BTC3_WMASK;
      if (awaddr_reg == ptcw_pkg::ADDR_CTRL)
        ctrl_reg <= wdata_reg & ptcw_pkg::CTRL_WMASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // read channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= ptcw_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= ptcw_pkg::RESP_OKAY;
      if (s_axi_araddr == ptcw_pkg::ADDR_BTC3)
        s_axi_rdata <= {24'h000000, btc3_reg & ptcw_pkg::BTC3_WMASK};
      else if (s_axi_araddr == ptcw_pkg::ADDR_CTRL)
        s_axi_rdata <= {24'h000000, ctrl_reg};
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= ptcw_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // clock output divider and pin select
  logic [7:0] div_cnt_reg;
  logic       div_q_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt_reg <= 8'h00;
      div_q_reg   <= 1'b0;
    end
    else if (div_cnt_reg == 8'(CLK_HALF - 1))
    begin
      div_cnt_reg <= 8'h00;
      div_q_reg   <= !div_q_reg;
    end
    else
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !clock_output_enable)
      clock_output_pin <= 1'b0;
    else if (frame_start_sel)
      clock_output_pin <= frame_start_pulse;
    else
      clock_output_pin <= div_q_reg;
  end
  ////////////////////////////////////////////////////////////////////////////
  // wake input sync and optional glitch filter
  logic       wake_meta_reg;
  logic       wake_sync_reg;
  logic [7:0] wake_cnt_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end
    else
    begin
      wake_meta_reg <= wake_pin;
      wake_sync_reg <= wake_meta_reg;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !wake_sync_reg)
    begin
      wake_cnt_reg <= 8'h00;
      wake_event   <= 1'b0;
    end
    else
    begin
      if (wake_cnt_reg != 8'(WAKE_CYCLES))
        wake_cnt_reg <= wake_cnt_reg + 8'h01;
      if (wake_filter_enable)
        wake_event <= (wake_cnt_reg >= 8'(WAKE_CYCLES - 1));
      else
        wake_event <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  ptcw_phase_two_timer u_phase_two_timer
  (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .time_quantum_tick (time_quantum_tick),
    .start             (phase_two_start),
    .length_field      (phase_segment_two_length),
    .busy              (phase_two_busy),
    .done              (phase_two_done)
  );
  ////////////////////////////////////////////////////////////////////////////
  property p_sof_pin;
    @(posedge aclk) disable iff (!aresetn)
    (clock_output_enable && frame_start_sel)
      |=> clock_output_pin == $past(frame_start_pulse);
  endproperty
  a_sof_pin: assert property (p_sof_pin)
    else $error("pin not following frame start");
  property p_clk_pin;
    @(posedge aclk) disable iff (!aresetn)
    (clock_output_enable && !frame_start_sel)
      |=> clock_output_pin == $past(div_q_reg);
  endproperty
  a_clk_pin: assert property (p_clk_pin)
    else $error("pin not following divided clock");
  property p_pin_off;
    @(posedge aclk) disable iff (!aresetn)
    !clock_output_enable |=> !clock_output_pin;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin active while output disabled");
  property p_wake_raw;
    @(posedge aclk) disable iff (!aresetn)
    !wake_filter_enable |=> wake_event == $past(wake_sync_reg);
  endproperty
  a_wake_raw: assert property (p_wake_raw)
    else $error("unfiltered wake not passed through");
  property p_wake_filt;
    @(posedge aclk) disable iff (!aresetn)
    (WAKE_CYCLES > 1 && wake_filter_enable && $rose(wake_sync_reg))
      |=> !wake_event;
  endproperty
  a_wake_filt: assert property (p_wake_filt)
    else $error("filtered wake passed a short pulse");
  property p_read_zero;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[5:3] == 3'h0;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("unimplemented bits read nonzero");
  property p_store;
    @(posedge aclk) disable iff (!aresetn)
    (do_write && wstrb0_reg && awaddr_reg == ptcw_pkg::ADDR_BTC3)
      |=> btc3_reg == ($past(wdata_reg) & ptcw_pkg::BTC3_WMASK);
  endproperty
  a_store: assert property (p_store)
    else $error("config write not stored as masked");
  cover property (@(posedge aclk) disable iff (!aresetn)
    clock_output_enable && frame_start_sel && clock_output_pin);
  cover property (@(posedge aclk) disable iff (!aresetn)
    wake_filter_enable && wake_event);
  cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

//--- verif/phase2_clock_output_pin_wake_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module phase2_clock_output_pin_wake_config_tb;
  logic        aclk;
  logic        aresetn;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        fsp;
  logic        quantum_tick;
  logic        seg_two_go;
  logic        wake_pin;
  logic        pin;
  logic        wake_event;
  logic        seg_two_busy;
  logic        seg_two_done;
  int          fails;
  int          n_checks;
  logic [7:0]  wr_v [4] = '{8'hFF, 8'h38, 8'h85, 8'h42};
  logic [7:0]  rd_v [4] = '{8'hC7, 8'h00, 8'h85, 8'h42};

  ptcw_top #(.WAKE_CYCLES(2), .CLK_HALF(1)) uut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frame_start_pulse(fsp),
    .time_quantum_tick(quantum_tick), .phase_two_start(seg_two_go),
    .wake_pin(wake_pin), .clock_output_pin(pin), .wake_event(wake_event),
    .phase_two_busy(seg_two_busy), .phase_two_done(seg_two_done)
  );

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
    @(posedge aclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", {24'h0, ed}, rdata)
    `CHK("rresp", er, rresp)
    @(posedge aclk);
  endtask

  // pin level over three settled cycles
  task automatic pin_hold(input logic v);
    repeat (2) @(posedge aclk);
    repeat (3)
    begin
      @(posedge aclk);
      #1 `CHK("clock_output_pin", v, pin)
    end
  endtask

  // one-cycle wake pulse, reports whether any wake seen
  task automatic wake_pulse(input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge aclk);
    wake_pin <= 1'b1;
    @(posedge aclk);
    wake_pin <= 1'b0;
    repeat (8)
    begin
      @(posedge aclk);
      #1 seen = seen | wake_event;
    end
    `CHK("wake_event", exp, seen)
  endtask

  // quantum ticks held low for stall cycles after the start edge
  task automatic seg_two_run(input logic [2:0] f, input int stall);
    int n;
    wr(ptcw_pkg::ADDR_BTC3, {5'h0, f}, 4'h1, ptcw_pkg::RESP_OKAY);
    @(posedge aclk);
    seg_two_go <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      seg_two_go <= 1'b0;
      n++;
      quantum_tick <= (n > stall);
      #1;
      if (n == 1) `CHK("seg two busy", 1'b1, seg_two_busy)
    end while (seg_two_done !== 1'b1 && n < 40);
    `CHK("seg two cycles", int'(f) + stall + 2, n)
    `CHK("seg two busy end", 1'b0, seg_two_busy)
  endtask

  initial
  begin
    #200000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    {fails, n_checks} = '0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, fsp, seg_two_go, wake_pin} = '0;
    quantum_tick = 1'b1;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ptcw_pkg::ADDR_BTC3, 8'h00, ptcw_pkg::RESP_OKAY);
    rd(ptcw_pkg::ADDR_CTRL, 8'h00, ptcw_pkg::RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(ptcw_pkg::ADDR_BTC3, wr_v[i], 4'h1, ptcw_pkg::RESP_OKAY);
      rd(ptcw_pkg::ADDR_BTC3, rd_v[i], ptcw_pkg::RESP_OKAY);
    end
    wr(ptcw_pkg::ADDR_BTC3, 8'h07, 4'h0, ptcw_pkg::RESP_OKAY);
    rd(ptcw_pkg::ADDR_BTC3, 8'h42, ptcw_pkg::RESP_OKAY);
    wr(4'h8, 8'hFF, 4'h1, ptcw_pkg::RESP_SLVERR);
    rd(4'h8, 8'h00, ptcw_pkg::RESP_SLVERR);
    wr(ptcw_pkg::ADDR_CTRL, 8'hFB, 4'h1, ptcw_pkg::RESP_OKAY);
    rd(ptcw_pkg::ADDR_CTRL, 8'h00, ptcw_pkg::RESP_OKAY);
    // output disabled: select has no effect
    wr(ptcw_pkg::ADDR_BTC3, 8'h80, 4'h1, ptcw_pkg::RESP_OKAY);
    fsp <= 1'b1;
    pin_hold(1'b0);
    wr(ptcw_pkg::ADDR_BTC3, 8'h00, 4'h1, ptcw_pkg::RESP_OKAY);
    pin_hold(1'b0);
    wr(ptcw_pkg::ADDR_CTRL, 8'h04, 4'h1, ptcw_pkg::RESP_OKAY);
    repeat (4)
    begin
      logic p0;
      @(posedge aclk);
      #1 p0 = pin;
      @(posedge aclk);
      #1 `CHK("divided clock", ~p0, pin)
    end
    wr(ptcw_pkg::ADDR_BTC3, 8'h80, 4'h1, ptcw_pkg::RESP_OKAY);
    pin_hold(1'b1);
    fsp <= 1'b0;
    pin_hold(1'b0);
    wr(ptcw_pkg::ADDR_BTC3, 8'h00, 4'h1, ptcw_pkg::RESP_OKAY);
    wake_pulse(1'b1);
    wr(ptcw_pkg::ADDR_BTC3, 8'h40, 4'h1, ptcw_pkg::RESP_OKAY);
    wake_pulse(1'b0);
    wake_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    #1 `CHK("wake_event held", 1'b1, wake_event)
    wake_pin <= 1'b0;
    seg_two_run(3'h0, 0);
    seg_two_run(3'h7, 0);
    seg_two_run(3'h3, 4);
    report_and_stop();
  end
endmodule
`default_nettype wire
